// file: logic/afe_mode_pkg.sv
/*
 * Constants and types for the serial mode and test control registers.
 * Assumes nothing beyond a SystemVerilog-2012 compiler.
 */
`default_nettype none

package afe_mode_pkg;

    // Serial frame layout.
    localparam int        FRAME_BITS   = 11;
    localparam int        SELECT_BITS  = 3;
    localparam int        DATA_BITS    = 8;
    localparam int        COUNT_BITS   = 4;

    // Register select codes.
    localparam logic [2:0] SEL_OPERATING_MODE = 3'h6;
    localparam logic [2:0] SEL_MODE_AND_TEST  = 3'h7;

    // Values after reset.
    localparam logic [7:0] OPERATING_MODE_RESET = 8'h00;
    localparam logic [7:0] MODE_AND_TEST_RESET  = 8'h00;

    // Operating mode field positions.
    localparam int POS_POWER_DOWN    = 7;
    localparam int POS_DIGITAL_RESET = 6;
    localparam int POS_TOP_REF       = 5;
    localparam int POS_DC_REF        = 4;
    localparam int POS_AC_COUPLED    = 3;
    localparam int POS_INVERTED      = 2;
    localparam int POS_SIG_CFG       = 0;

    // Mode and test field positions.
    localparam int POS_FIFTH_TEST    = 7;
    localparam int POS_OUT_DISABLE   = 6;
    localparam int POS_DAC_RANGE     = 5;
    localparam int POS_CIS_REF       = 4;
    localparam int POS_FIRST_TEST    = 0;

    // Channel codes for input and gain/offset selection.
    typedef enum logic [1:0] {
        CH_RED   = 2'b00,
        CH_GREEN = 2'b01,
        CH_BLUE  = 2'b10
    } channel_t;

    // Signal configuration codes.
    localparam logic [1:0] CFG_RED_ONLY   = 2'b00;
    localparam logic [1:0] CFG_RED_CYCLE  = 2'b01;

    // Decoded operating settings seen by the analog side.
    typedef struct packed {
        logic       powerDown;
        logic       topRefExternal;
        logic       dcRefExternal;
        logic       acCoupled;
        logic       inverted;
        logic       dacRangeWide;
        logic       cisRefEnable;
        logic [4:0] testModes;
    } settings_t;

    // Channel selections driven to the signal path each pixel.
    typedef struct packed {
        channel_t inputSel;
        channel_t gainOffsetSel;
    } chansel_t;

endpackage

`default_nettype wire

// file: logic/pin_sync.sv
/*
 * Three-stage synchroniser for one pin with change detection.
 * Assumes the pin is asynchronous to mclk.
 */
`timescale 1ns/1ns
`default_nettype none

module pin_sync (
    // Clock and reset.
    input  wire logic mclk,
    input  wire logic resetn,
    // Pin and reset level.
    input  wire logic pinIn,
    input  wire logic idleLevel,
    // Filtered level and edges.
    output logic      level,
    output logic      rise,
    output logic      fall
);

    logic [2:0] stage_q;

    // Stage 0 feeds only stage 1; stages 1 and 2 decide a change.
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            // Starting at the idle level keeps a false edge from following reset.
            stage_q <= {3{idleLevel}};
        end else begin
            stage_q <= {stage_q[1], stage_q[0], pinIn};
        end
    end

    logic level_q;
    logic seeded_q;

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            level_q  <= 1'b0;
            seeded_q <= 1'b0;
        end else if (!seeded_q) begin
            level_q  <= idleLevel;
            seeded_q <= 1'b1;
        end else if (stage_q[2] == stage_q[1]) begin
            level_q  <= stage_q[2];
        end
    end

    assign level = level_q;
    assign rise  = seeded_q && (stage_q[2] == stage_q[1]) &&
                   stage_q[2] && !level_q;
    assign fall  = seeded_q && (stage_q[2] == stage_q[1]) &&
                   !stage_q[2] && level_q;

endmodule // pin_sync

`default_nettype wire

// file: logic/afe_mode_regs.sv
/*
 * Serially loaded operating-mode and mode-and-test control registers,
 * pixel channel sequencing and the shared output bus drivers.
 * Assumes pixelTick and lineStart come from logic on mclk, and that the
 * serial pins are asynchronous and sampled here.
 */
`timescale 1ns/1ns
`default_nettype none

module afe_mode_regs
    import afe_mode_pkg::*;
#(
    parameter int BUS_WIDTH = 8
) (
    // Clock and reset.
    input  wire logic                 mclk,
    input  wire logic                 resetn,
    // Shared parallel output and serial pins.
    input  wire logic [BUS_WIDTH-1:0] busIn,
    output logic [BUS_WIDTH-1:0]      busOut,
    output logic [BUS_WIDTH-1:0]      busOe,
    // Pixel data and timing from the converter side.
    input  wire logic [BUS_WIDTH-1:0] pixelByte,
    input  wire logic                 pixelTick,
    input  wire logic                 lineStart,
    // Decoded settings and per-pixel channel choice.
    output settings_t                 settings,
    output chansel_t                  chanSel,
    output logic [7:0]                operatingMode,
    output logic [7:0]                modeAndTest
);

    if (BUS_WIDTH != 8) begin : g_width_check
        $error("afe_mode_regs: BUS_WIDTH must be 8");
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin sampling.

    localparam int PIN_SCLK = 5;
    localparam int PIN_SDATA = 6;
    localparam int PIN_LOAD = 7;

    logic sclkLevel, sclkRise;
    logic sdataLevel;
    logic loadRise, loadFall;

    pin_sync u_sclk (
        .mclk      (mclk),
        .resetn    (resetn),
        .pinIn     (busIn[PIN_SCLK]),
        .idleLevel (1'b0),
        .level     (sclkLevel),
        .rise      (sclkRise),
        .fall      ()
    );

    pin_sync u_sdata (
        .mclk      (mclk),
        .resetn    (resetn),
        .pinIn     (busIn[PIN_SDATA]),
        .idleLevel (1'b0),
        .level     (sdataLevel),
        .rise      (),
        .fall      ()
    );

    pin_sync u_load (
        .mclk      (mclk),
        .resetn    (resetn),
        .pinIn     (busIn[PIN_LOAD]),
        .idleLevel (1'b1),
        .level     (),
        .rise      (loadRise),
        .fall      (loadFall)
    );

    ////////////////////////////////////////////////////////////////////////
    // Serial frame capture.

    logic [FRAME_BITS-1:0] shift_q;
    logic [COUNT_BITS-1:0] count_q;
    logic                  inFrame_q;

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            shift_q   <= '0;
            count_q   <= '0;
            inFrame_q <= 1'b0;
        end else if (loadFall) begin
            count_q   <= '0;
            inFrame_q <= 1'b1;
        end else if (loadRise) begin
            inFrame_q <= 1'b0;
        end else if (inFrame_q && sclkRise &&
                     count_q < COUNT_BITS'(FRAME_BITS)) begin
            shift_q <= {shift_q[FRAME_BITS-2:0], sdataLevel};
            count_q <= count_q + 4'h1;
        end
    end

    logic                  commit;
    logic [SELECT_BITS-1:0] frameSel;
    logic [DATA_BITS-1:0]  frameData;

    assign commit    = loadRise && inFrame_q &&
                       count_q == COUNT_BITS'(FRAME_BITS);
    assign frameSel  = shift_q[FRAME_BITS-1 -: SELECT_BITS];
    assign frameData = shift_q[DATA_BITS-1:0];

    ////////////////////////////////////////////////////////////////////////
    // Register file.

    logic [7:0] mode_q;
    logic [7:0] test_q;

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            mode_q <= OPERATING_MODE_RESET;
            test_q <= MODE_AND_TEST_RESET;
        end else if (commit && frameSel == SEL_OPERATING_MODE) begin
            if (frameData[POS_DIGITAL_RESET]) begin
                mode_q <= OPERATING_MODE_RESET;
                test_q <= MODE_AND_TEST_RESET;
            end else if (frameData[POS_POWER_DOWN]) begin
                mode_q <= {frameData[7:2], CFG_RED_ONLY};
            end else begin
                mode_q <= frameData;
            end
        end else if (commit && frameSel == SEL_MODE_AND_TEST) begin
            test_q <= frameData;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pixel channel sequencing.

    function automatic channel_t next_channel(input channel_t ch);
        case (ch)
            CH_RED:   next_channel = CH_GREEN;
            CH_GREEN: next_channel = CH_BLUE;
            default:  next_channel = CH_RED;
        endcase
    endfunction

    channel_t   phase_q;
    logic [1:0] sigCfg;

    assign sigCfg = mode_q[POS_SIG_CFG +: 2];

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            phase_q <= CH_RED;
        end else if (lineStart || sigCfg == CFG_RED_ONLY) begin
            phase_q <= CH_RED;
        end else if (pixelTick) begin
            phase_q <= next_channel(phase_q);
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            chanSel <= '{inputSel: CH_RED, gainOffsetSel: CH_RED};
        end else if (sigCfg == CFG_RED_ONLY) begin
            chanSel <= '{inputSel: CH_RED, gainOffsetSel: CH_RED};
        end else if (sigCfg == CFG_RED_CYCLE) begin
            chanSel <= '{inputSel: CH_RED, gainOffsetSel: phase_q};
        end else begin
            chanSel <= '{inputSel: phase_q, gainOffsetSel: phase_q};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Settings and output drivers.

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            settings      <= '0;
            operatingMode <= OPERATING_MODE_RESET;
            modeAndTest   <= MODE_AND_TEST_RESET;
        end else begin
            settings.powerDown      <= mode_q[POS_POWER_DOWN];
            settings.topRefExternal <= mode_q[POS_TOP_REF];
            settings.dcRefExternal  <= mode_q[POS_DC_REF];
            settings.acCoupled      <= mode_q[POS_AC_COUPLED];
            settings.inverted       <= mode_q[POS_INVERTED];
            settings.dacRangeWide   <= test_q[POS_DAC_RANGE];
            settings.cisRefEnable   <= test_q[POS_CIS_REF];
            settings.testModes      <= {test_q[POS_FIFTH_TEST],
                                        test_q[3:POS_FIRST_TEST]};
            operatingMode           <= mode_q;
            modeAndTest             <= test_q;
        end
    end

    // Serial pins are released while a frame is open so the controller
    // can drive them without contention.
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            busOut <= '0;
            busOe  <= '0;
        end else begin
            busOut <= pixelByte;
            if (test_q[POS_OUT_DISABLE] || inFrame_q) begin
                busOe <= '0;
            end else begin
                busOe <= '1;
            end
        end
    end

endmodule // afe_mode_regs

`default_nettype wire

// file: testbench/afe_mode_regs_properties.sv
/* Checker for the serial control registers.
   Bound to afe_mode_regs and sees only its ports. */
`timescale 1ns/1ns
`default_nettype none
module afe_mode_regs_checker
    import afe_mode_pkg::*;
#(parameter int BUS_WIDTH = 8) (
    // Clock and reset.
    input wire logic                 mclk,
    input wire logic                 resetn,
    // Pins and pixel side.
    input wire logic [BUS_WIDTH-1:0] busIn,
    input wire logic [BUS_WIDTH-1:0] busOut,
    input wire logic [BUS_WIDTH-1:0] busOe,
    input wire logic [BUS_WIDTH-1:0] pixelByte,
    input wire logic                 pixelTick,
    input wire logic                 lineStart,
    // Register view.
    input wire settings_t            settings,
    input wire chansel_t             chanSel,
    input wire logic [7:0]           operatingMode,
    input wire logic [7:0]           modeAndTest
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    ref_select_a: assert property (
        settings.topRefExternal == operatingMode[POS_TOP_REF])
        else $error("reference select mismatch");
    pd_decode_a: assert property (
        settings.powerDown == operatingMode[POS_POWER_DOWN])
        else $error("power-down decode mismatch");
    pd_config_a: assert property (
        operatingMode[POS_POWER_DOWN] |-> operatingMode[1:0] == 2'b00)
        else $error("configuration kept in power-down");
    reset_bit_a: assert property (
        operatingMode[POS_DIGITAL_RESET] == 1'b0)
        else $error("digital reset bit stored");
    red_input_a: assert property (
        operatingMode[1:0] == CFG_RED_CYCLE
        && $past(operatingMode[1:0]) == CFG_RED_CYCLE
        |-> chanSel.inputSel == CH_RED)
        else $error("input not red");
    triple_lock_a: assert property (
        operatingMode[1] && $past(operatingMode[1])
        |-> chanSel.inputSel == chanSel.gainOffsetSel)
        else $error("input and gain channel differ");
    frame_hold_a: assert property (
        (!busIn[7]) [*8] |=> $stable(operatingMode) && $stable(modeAndTest))
        else $error("register changed in open frame");
    out_off_a: assert property (
        modeAndTest[POS_OUT_DISABLE] && $past(modeAndTest[POS_OUT_DISABLE])
        |-> busOe == '0)
        else $error("outputs driven while disabled");
    out_on_a: assert property (
        (busIn[7] && !modeAndTest[POS_OUT_DISABLE]) [*8] |-> busOe == '1)
        else $error("outputs released while enabled");
    bus_copy_a: assert property (
        $past(resetn) |-> busOut == $past(pixelByte))
        else $error("output bus not one cycle behind pixel data");
    line_start_a: assert property (
        lineStart |-> ##2 chanSel.gainOffsetSel == CH_RED)
        else $error("gain channel not red after line start");
endmodule // afe_mode_regs_checker

bind afe_mode_regs afe_mode_regs_checker #(.BUS_WIDTH(BUS_WIDTH)) i_chk (
    .mclk(mclk), .resetn(resetn), .busIn(busIn), .busOut(busOut),
    .busOe(busOe), .pixelByte(pixelByte), .pixelTick(pixelTick),
    .lineStart(lineStart), .settings(settings), .chanSel(chanSel),
    .operatingMode(operatingMode), .modeAndTest(modeAndTest));
`default_nettype wire

// file: testbench/scan_ctrl_model.sv
/* Controller model that loads frames over the serial pins.
   Assumes mclk at 100 MHz; the serial clock is idle outside frames. */
`timescale 1ns/1ns
`default_nettype none
module scan_ctrl_model (
    // Clock.
    input  wire logic mclk,
    // Serial pins.
    output logic      sclk,
    output logic      sdata,
    output logic      loadn
);
    initial begin
        sclk  = 1'b0;
        sdata = 1'b0;
        loadn = 1'b1;
    end
    // Clocks past the eleventh carry filler bits.
    task automatic send(input logic [10:0] frame, input int n);
        int i;
        @(posedge mclk) loadn <= 1'b0;
        for (i = 0; i < n; i++) begin
            sdata <= (i < 11) ? frame[10 - i] : ~sdata;
            repeat (6) @(posedge mclk);
            sclk <= 1'b1;
            repeat (6 + i % 2) @(posedge mclk);
            sclk <= 1'b0;
        end
        repeat (6) @(posedge mclk);
        loadn <= 1'b1;
        sdata <= ~sdata;
    endtask
endmodule // scan_ctrl_model
`default_nettype wire

// file: testbench/test_afe_mode_regs.sv
/* Self-checking bench for the serial control registers.
   Drives pixel timing and steers the controller model. */
`timescale 1ns/1ns
`default_nettype none
module test_afe_mode_regs
    import afe_mode_pkg::*;
;
    logic       mclk;
    logic       resetn;
    logic       pixelTick;
    logic       lineStart;
    logic       sclk;
    logic       sdata;
    logic       loadn;
    logic [7:0] pixelByte;
    logic [7:0] busOe;
    logic [7:0] busOut;
    logic [7:0] operatingMode;
    logic [7:0] modeAndTest;
    settings_t  settings;
    chansel_t   chanSel;
    int         err_total = 0;
    int         n_checks = 0;

    afe_mode_regs i_afe_mode_regs (
        .mclk(mclk), .resetn(resetn), .busIn({loadn, sdata, sclk, 5'h00}),
        .busOut(busOut), .busOe(busOe), .pixelByte(pixelByte),
        .pixelTick(pixelTick), .lineStart(lineStart), .settings(settings),
        .chanSel(chanSel), .operatingMode(operatingMode),
        .modeAndTest(modeAndTest));
    scan_ctrl_model ctrl (
        .mclk(mclk), .sclk(sclk), .sdata(sdata), .loadn(loadn));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: %h not %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic wr(input logic [2:0] sel, input logic [7:0] d,
                      input int n = 11);
        ctrl.send({sel, d}, n);
        repeat (12) @(posedge mclk);
        #1;
    endtask
    task automatic pulse(input logic ls);
        @(posedge mclk) begin
            pixelTick <= !ls;
            lineStart <= ls;
            pixelByte <= pixelByte + 8'h01;
        end
        @(posedge mclk) begin
            pixelTick <= 1'b0;
            lineStart <= 1'b0;
        end
        repeat (3) @(posedge mclk);
        #1;
    endtask

    task automatic sc_regs;
        chk(operatingMode, OPERATING_MODE_RESET);
        chk(modeAndTest, MODE_AND_TEST_RESET);
        wr(SEL_OPERATING_MODE, 8'h3d);
        chk(operatingMode, 8'h3d);
        chk(8'(settings.topRefExternal), 8'h01);
        wr(SEL_OPERATING_MODE, 8'h92, 10);
        chk(operatingMode, 8'h3d);
        wr(3'h2, 8'hff);
        chk(operatingMode, 8'h3d);
        wr(SEL_MODE_AND_TEST, 8'h30, 14);
        chk(modeAndTest, 8'h30);
        wr(SEL_OPERATING_MODE, 8'h1c);
        chk(8'(settings.topRefExternal), 8'h00);
    endtask
    task automatic sc_pd;
        wr(SEL_OPERATING_MODE, 8'h9d);
        chk(operatingMode, 8'h9c);
        chk(modeAndTest, 8'h30);
        chk(16'(settings), 16'h0be0);
        wr(SEL_OPERATING_MODE, 8'h1e);
        chk(operatingMode, 8'h1e);
        wr(SEL_OPERATING_MODE, 8'h4a);
        chk(operatingMode, 8'h00);
        chk(modeAndTest, 8'h00);
    endtask
    task automatic sc_oe;
        wr(SEL_MODE_AND_TEST, 8'hc5);
        chk(busOe, 8'h00);
        chk(16'(settings), 16'h0015);
        wr(SEL_MODE_AND_TEST, 8'h00);
        chk(busOe, 8'hff);
    endtask
    task automatic sc_cycle(input logic [1:0] cfg);
        int k;
        wr(SEL_OPERATING_MODE, {6'h00, cfg});
        pulse(1'b1);
        for (k = 0; k < 4; k++) begin
            chk(8'(chanSel.gainOffsetSel), 8'(k % 3));
            chk(8'(chanSel.inputSel), cfg[1] ? 8'(k % 3) : 8'h00);
            chk(busOut, pixelByte);
            pulse(1'b0);
        end
    endtask

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        resetn = 1'b0;
        pixelTick = 1'b0;
        lineStart = 1'b0;
        pixelByte = 8'h00;
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        repeat (8) @(posedge mclk);
        #1;
        sc_regs();
        sc_pd();
        sc_oe();
        sc_cycle(2'b01);
        sc_cycle(2'b10);
        sc_cycle(2'b11);
        wrap_up();
    end
    initial begin
        #200000;
        err_total++;
        wrap_up();
    end
endmodule // test_afe_mode_regs
`default_nettype wire
